// ==== rtl/scan_cmd_pkg.sv ====
// Shared constants and carrier types for the scan, scroll and idle command block
package scan_cmd_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SCROLL_AREA_DEFINE = 8'h33;
  localparam logic [7:0] CMD_SCAN_DIRECTION = 8'h36;
  localparam logic [7:0] CMD_SCROLL_START = 8'h37;
  localparam logic [7:0] CMD_REDUCED_COLOUR_EXIT = 8'h38;

  // ----------------------------------------------------------------
  // Register offsets (the command code selects the register)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SCAN_DIRECTION_CTRL = 8'h36;
  localparam logic [7:0] OFS_SCROLL_START_LINE_POINTER = 8'h37;

  // ----------------------------------------------------------------
  // Field positions of the scan direction parameter byte
  // ----------------------------------------------------------------
  localparam int BIT_ROW_ORDER_FLIP = 7;
  localparam int BIT_COLUMN_ORDER_FLIP = 6;
  localparam int BIT_ROW_COLUMN_SWAP = 5;
  localparam int BIT_VERTICAL_REFRESH_FLIP = 4;
  localparam int BIT_COLOUR_FILTER_ORDER = 3;
  localparam int BIT_HORIZONTAL_REFRESH_FLIP = 2;

  // ----------------------------------------------------------------
  // Widths, reset values and geometry
  // ----------------------------------------------------------------
  localparam int HOST_DATA_W = 18;
  localparam int LINE_W = 16;
  localparam int SCROLL_DEF_PARAMS = 6;
  localparam logic [7:0] SCAN_DIRECTION_RESET = 8'h00;
  localparam logic [15:0] SCROLL_POINTER_RESET = 16'h0000;
  localparam logic [15:0] TOP_FIXED_RESET = 16'h0000;
  localparam logic [15:0] SCROLL_HEIGHT_RESET = 16'h0140;
  localparam logic [15:0] BOTTOM_FIXED_RESET = 16'h0000;
  localparam logic [15:0] PANEL_LAST_LINE = 16'h013F;
  localparam logic [2:0] DEF_LAST_INDEX = 3'h5;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic row_order_flip;
    logic column_order_flip;
    logic row_column_swap;
    logic vertical_refresh_flip;
    logic colour_filter_order;
    logic horizontal_refresh_flip;
  } access_ctrl_t;

  typedef struct packed {
    logic [15:0] top_fixed_lines;
    logic [15:0] scroll_area_height;
    logic [15:0] bottom_fixed_lines;
  } scroll_def_t;

  typedef enum logic [2:0] {
    ST_CMD,
    ST_SCAN_PARAM,
    ST_PTR_HIGH,
    ST_PTR_LOW,
    ST_DEF_PARAM
  } parse_state_t;

endpackage

// ==== rtl/lcd_scan_scroll_idle_cmds.sv ====
// Host command interpreter for scan direction, scroll start pointer and idle exit
`timescale 1ns/1ps

// Notes on behaviour
// - Code 36h loads next parameter as scan setting
// - Scan setting write changes nothing else
// - Row, column, swap bits steer address stepping
// - Vertical refresh bit flips panel line order
// - Horizontal refresh bit flips pixel order
// - Colour order bit: zero RGB, one COLOUR_FILTER_ORDER
// - Colour order change acts at once
// - Scan setting zero on reset, kept on soft
// - Code 37h takes pointer, high byte first
// - Pointer combines with scroll area definition
// - New pointer applied at next panel scan
// - Pointer command ignored in partial mode
// - Pointer zero after every reset kind
// - Code 38h leaves idle, full colour
// - Idle exit when already off does nothing
// - Idle off after every reset kind
// - Vertical refresh bit picks fixed area origin
// - Area definition three lines counts, reset values
module lcd_scan_scroll_idle_cmds (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cmd_param_select,
  input wire logic write_strobe_n,
  input wire logic [scan_cmd_pkg::HOST_DATA_W-1:0] host_data,
  input wire logic soft_reset,
  input wire logic partial_mode,
  input wire logic idle_enter,
  input wire logic frame_start,
  input wire logic [scan_cmd_pkg::LINE_W-1:0] disp_line,
  output scan_cmd_pkg::access_ctrl_t access_ctrl,
  output logic idle_mode,
  output logic [scan_cmd_pkg::LINE_W-1:0] scroll_pointer_value,
  output scan_cmd_pkg::scroll_def_t scroll_def,
  output logic [scan_cmd_pkg::LINE_W-1:0] fm_line
);
  import scan_cmd_pkg::*;

  // ----------------------------------------------------------------
  // Host strobe capture
  // ----------------------------------------------------------------
  logic strobe_n_r;
  logic wr_event;
  logic is_cmd;
  logic is_param;
  logic [7:0] byte_in;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      strobe_n_r <= 1'b1;
    end else begin
      strobe_n_r <= write_strobe_n;
    end
  end

  // rising strobe edge takes the byte
  assign wr_event = !strobe_n_r && write_strobe_n;
  assign is_cmd = wr_event && !cmd_param_select;
  assign is_param = wr_event && cmd_param_select;
  // upper lines ignored, only the low byte counts
  assign byte_in = host_data[7:0];

  // ----------------------------------------------------------------
  // Command parser
  // ----------------------------------------------------------------
  parse_state_t state_r;
  logic [2:0] def_idx_r;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_CMD;
    end else if (is_cmd) begin
      unique case (byte_in)
        CMD_SCAN_DIRECTION: state_r <= ST_SCAN_PARAM;
        // pointer command dropped while partial mode is on
        CMD_SCROLL_START: state_r <= partial_mode ? ST_CMD : ST_PTR_HIGH;
        CMD_SCROLL_AREA_DEFINE: state_r <= ST_DEF_PARAM;
        default: state_r <= ST_CMD;
      endcase
    end else if (is_param) begin
      unique case (state_r)
        ST_SCAN_PARAM: state_r <= ST_CMD;
        ST_PTR_HIGH: state_r <= ST_PTR_LOW;
        ST_PTR_LOW: state_r <= ST_CMD;
        ST_DEF_PARAM: state_r <= (def_idx_r == DEF_LAST_INDEX) ? ST_CMD : ST_DEF_PARAM;
        ST_CMD: state_r <= ST_CMD;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      def_idx_r <= 3'h0;
    end else if (is_cmd) begin
      def_idx_r <= 3'h0;
    end else if (is_param && state_r == ST_DEF_PARAM) begin
      def_idx_r <= def_idx_r + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Scan direction setting
  // ----------------------------------------------------------------
  access_ctrl_t access_r;

  // cleared only by hardware reset; soft reset leaves it
  // the write touches this register alone
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      access_r <= access_ctrl_t'(SCAN_DIRECTION_RESET[7:2]);
    end else if (is_param && state_r == ST_SCAN_PARAM) begin
      // parameter byte becomes the scan setting
      access_r.row_order_flip <= byte_in[BIT_ROW_ORDER_FLIP];
      access_r.column_order_flip <= byte_in[BIT_COLUMN_ORDER_FLIP];
      access_r.row_column_swap <= byte_in[BIT_ROW_COLUMN_SWAP];
      access_r.vertical_refresh_flip <= byte_in[BIT_VERTICAL_REFRESH_FLIP];
      access_r.colour_filter_order <= byte_in[BIT_COLOUR_FILTER_ORDER];
      access_r.horizontal_refresh_flip <= byte_in[BIT_HORIZONTAL_REFRESH_FLIP];
    end
  end

  // address stepping, refresh order and colour filter leave directly
  // vertical refresh order drives the panel at once
  // colour filter order, zero RGB, one COLOUR_FILTER_ORDER
  // no shadowing, so a colour order change is visible next cycle
  assign access_ctrl = access_r;

  // ----------------------------------------------------------------
  // Scroll start pointer
  // ----------------------------------------------------------------
  logic [7:0] ptr_high_r;
  logic [15:0] ptr_pend_r;
  logic pend_valid_r;
  logic [15:0] ptr_act_r;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ptr_high_r <= 8'h00;
    end else if (soft_reset) begin
      ptr_high_r <= 8'h00;
    end else if (is_param && state_r == ST_PTR_HIGH) begin
      ptr_high_r <= byte_in;
    end
  end

  // low byte completes the pointer, high byte first
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ptr_pend_r <= SCROLL_POINTER_RESET;
      pend_valid_r <= 1'b0;
    end else if (soft_reset) begin
      ptr_pend_r <= SCROLL_POINTER_RESET;
      pend_valid_r <= 1'b0;
    end else if (is_param && state_r == ST_PTR_LOW) begin
      ptr_pend_r <= {ptr_high_r, byte_in};
      pend_valid_r <= 1'b1;
    end else if (frame_start) begin
      pend_valid_r <= 1'b0;
    end
  end

  // a frame never shows a half-applied pointer
  // every reset kind clears the live pointer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ptr_act_r <= SCROLL_POINTER_RESET;
    end else if (soft_reset) begin
      ptr_act_r <= SCROLL_POINTER_RESET;
    end else if (frame_start && pend_valid_r) begin
      ptr_act_r <= ptr_pend_r;
    end
  end

  assign scroll_pointer_value = ptr_act_r;

  // ----------------------------------------------------------------
  // Scroll area definition
  // ----------------------------------------------------------------
  scroll_def_t def_r;

  // three 16-bit counts with their reset values
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      def_r <= {TOP_FIXED_RESET, SCROLL_HEIGHT_RESET, BOTTOM_FIXED_RESET};
    end else if (soft_reset) begin
      def_r <= {TOP_FIXED_RESET, SCROLL_HEIGHT_RESET, BOTTOM_FIXED_RESET};
    end else if (is_param && state_r == ST_DEF_PARAM) begin
      unique case (def_idx_r)
        3'h0: def_r.top_fixed_lines[15:8] <= byte_in;
        3'h1: def_r.top_fixed_lines[7:0] <= byte_in;
        3'h2: def_r.scroll_area_height[15:8] <= byte_in;
        3'h3: def_r.scroll_area_height[7:0] <= byte_in;
        3'h4: def_r.bottom_fixed_lines[15:8] <= byte_in;
        3'h5: def_r.bottom_fixed_lines[7:0] <= byte_in;
        default: def_r <= def_r;
      endcase
    end
  end

  assign scroll_def = def_r;

  // ----------------------------------------------------------------
  // Idle mode
  // ----------------------------------------------------------------
  logic idle_r;

  // exit command restores full colour depth
  // clearing an already clear flag changes nothing
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      idle_r <= 1'b0;
    end else if (soft_reset) begin
      idle_r <= 1'b0;
    end else if (idle_enter) begin
      idle_r <= 1'b1;
    end else if (is_cmd && byte_in == CMD_REDUCED_COLOUR_EXIT) begin
      idle_r <= 1'b0;
    end
  end

  assign idle_mode = idle_r;

  // ----------------------------------------------------------------
  // Display line to frame-memory line mapping
  // ----------------------------------------------------------------
  logic [16:0] lv;
  logic [16:0] area_end;
  logic [16:0] shifted;
  logic [16:0] src;
  logic [15:0] fm_line_nxt;
  logic [15:0] fm_line_r;

  // pointer and area definition together pick the source line
  always_comb begin
    // with vertical flip the fixed area counts from the bottom
    if (access_r.vertical_refresh_flip) begin
      lv = {1'b0, PANEL_LAST_LINE} - {1'b0, disp_line};
    end else begin
      lv = {1'b0, disp_line};
    end
    area_end = {1'b0, def_r.top_fixed_lines} + {1'b0, def_r.scroll_area_height};
    // offset into area added to pointer, wrapped by area height
    shifted = {1'b0, ptr_act_r} + (lv - {1'b0, def_r.top_fixed_lines});
    if (lv < {1'b0, def_r.top_fixed_lines} || lv >= area_end) begin
      src = lv;
    end else if (shifted >= area_end) begin
      src = shifted - {1'b0, def_r.scroll_area_height};
    end else begin
      src = shifted;
    end
    if (access_r.vertical_refresh_flip) begin
      fm_line_nxt = PANEL_LAST_LINE - src[15:0];
    end else begin
      fm_line_nxt = src[15:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fm_line_r <= 16'h0000;
    end else begin
      fm_line_r <= fm_line_nxt;
    end
  end

  assign fm_line = fm_line_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  chk_scan_load: assert property (
    is_param && state_r == ST_SCAN_PARAM |=> access_ctrl == access_ctrl_t'($past(byte_in[7:2])))
    else $error("scan setting not loaded from parameter");

  chk_scan_isolated: assert property (
    is_param && state_r == ST_SCAN_PARAM && !soft_reset && !idle_enter
      |=> $stable(idle_mode) && $stable(scroll_def) && $stable(ptr_pend_r))
    else $error("scan setting write disturbed other state");

  chk_soft_keeps_scan: assert property (
    soft_reset && !(is_param && state_r == ST_SCAN_PARAM) |=> $stable(access_ctrl))
    else $error("soft reset altered scan setting");

  chk_ptr_frame_only: assert property (
    !$stable(scroll_pointer_value) |-> $past(frame_start) || $past(soft_reset))
    else $error("pointer changed outside a frame start");

  chk_ptr_two_bytes: assert property (
    is_param && state_r == ST_PTR_LOW && !soft_reset
      |=> ptr_pend_r == {$past(ptr_high_r), $past(byte_in)}
      && pend_valid_r)
    else $error("pointer bytes not assembled");

  chk_partial_ignore: assert property (
    is_cmd && byte_in == CMD_SCROLL_START && partial_mode |=> state_r == ST_CMD)
    else $error("pointer command accepted in partial mode");

  chk_ptr_soft_clear: assert property (
    soft_reset |=> scroll_pointer_value == SCROLL_POINTER_RESET && !pend_valid_r)
    else $error("pointer not cleared by soft reset");

  chk_idle_exit: assert property (
    is_cmd && byte_in == CMD_REDUCED_COLOUR_EXIT && !idle_enter |=> !idle_mode)
    else $error("idle exit left idle mode on");

  chk_idle_soft: assert property (
    soft_reset |=> !idle_mode)
    else $error("idle mode survived soft reset");

  chk_def_soft: assert property (
    soft_reset |=> scroll_def.scroll_area_height == SCROLL_HEIGHT_RESET)
    else $error("area height not restored");

  chk_fixed_top: assert property (
    !access_r.vertical_refresh_flip && disp_line < def_r.top_fixed_lines
      |=> fm_line == $past(disp_line))
    else $error("top fixed line remapped");

  chk_wrap_bound: assert property (
    !access_r.vertical_refresh_flip && disp_line >= def_r.top_fixed_lines
      && {1'b0, disp_line} < area_end && ptr_act_r < area_end[15:0]
      && ptr_act_r >= def_r.top_fixed_lines
      |=> fm_line >= $past(def_r.top_fixed_lines) && {1'b0, fm_line} < $past(area_end))
    else $error("scrolled line left the area");

  cov_scan_write: cover property (is_param && state_r == ST_SCAN_PARAM);
  cov_ptr_apply: cover property (pend_valid_r && frame_start);
  cov_partial_drop: cover property (is_cmd && byte_in == CMD_SCROLL_START && partial_mode);
  cov_idle_exit: cover property (idle_mode ##1 !idle_mode);

endmodule

// ==== tb/host_mcu_model.sv ====
// Host microcontroller model writing command codes and parameters
`timescale 1ns/1ps
module host_mcu_model (
  input wire logic core_clk,
  output logic cmd_param_select,
  output logic write_strobe_n,
  output logic [scan_cmd_pkg::HOST_DATA_W-1:0] host_data
);
  import scan_cmd_pkg::*;

  initial begin
    cmd_param_select = 1'b1;
    write_strobe_n = 1'b1;
    host_data = '0;
  end

  // ----------------------------------------------------------------
  // Byte transfer
  // ----------------------------------------------------------------
  // select level, strobe rise latches
  // byte on low lines, upper lines junk
  task automatic send(input logic sel, input logic [7:0] val, input logic [9:0] upper,
                      input int low_cycles);
    @(negedge core_clk);
    cmd_param_select = sel;
    host_data = {upper, val};
    write_strobe_n = 1'b0;
    repeat (low_cycles) @(negedge core_clk);
    write_strobe_n = 1'b1;
    @(negedge core_clk);
    // Released lines flip so stale values are never mistaken for data
    host_data = ~host_data;
    cmd_param_select = ~sel;
  endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the scan, scroll and idle command block
`timescale 1ns/1ps
module testbench;
  import scan_cmd_pkg::*;
  logic core_clk, nrst, soft_reset, partial_mode, idle_enter, frame_start, idle_mode;
  logic cmd_param_select, write_strobe_n;
  logic [HOST_DATA_W-1:0] host_data;
  logic [LINE_W-1:0] disp_line, scroll_pointer_value, fm_line, ptr, top, hgt;
  access_ctrl_t access_ctrl;
  scroll_def_t scroll_def;
  logic [31:0] seed = 32'h0000_77FB;
  logic [31:0] r;
  logic [7:0] b;
  logic [47:0] rst_def;
  int num_errors = 0;
  int num_checks = 0;

  lcd_scan_scroll_idle_cmds lcd_scan_scroll_idle_cmds_i (
    .core_clk(core_clk), .nrst(nrst), .cmd_param_select(cmd_param_select),
    .write_strobe_n(write_strobe_n), .host_data(host_data), .soft_reset(soft_reset),
    .partial_mode(partial_mode), .idle_enter(idle_enter), .frame_start(frame_start),
    .disp_line(disp_line), .access_ctrl(access_ctrl), .idle_mode(idle_mode),
    .scroll_pointer_value(scroll_pointer_value), .scroll_def(scroll_def), .fm_line(fm_line)
  );

  host_mcu_model host_mcu_model_i (
    .core_clk(core_clk), .cmd_param_select(cmd_param_select),
    .write_strobe_n(write_strobe_n), .host_data(host_data)
  );

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // One wrap only; the flip mirrors around the last panel line
  function automatic logic [15:0] map_line(input logic [15:0] d, input logic flip,
                                           input logic [15:0] t, input logic [15:0] h,
                                           input logic [15:0] p);
    int lv;
    int res;
    lv = flip ? int'(PANEL_LAST_LINE) - int'(d) : int'(d);
    res = lv;
    if (lv >= int'(t) && lv < int'(t) + int'(h)) begin
      res = int'(p) + lv - int'(t);
      if (res >= int'(t) + int'(h)) begin
        res = res - int'(h);
      end
    end
    if (flip) begin
      res = int'(PANEL_LAST_LINE) - res;
    end
    return res[15:0];
  endfunction

  task automatic check_val(input string name, input logic [47:0] exp, input logic [47:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_state(input logic [5:0] c, input logic i, input logic [15:0] p,
                             input logic [47:0] d);
    check_val("access_ctrl", 48'(c), 48'(access_ctrl));
    check_val("idle_mode", 48'(i), 48'(idle_mode));
    check_val("scroll_pointer_value", 48'(p), 48'(scroll_pointer_value));
    check_val("scroll_def", d, scroll_def);
  endtask

  task automatic wr(input logic sel, input logic [7:0] v);
    logic [31:0] x;
    x = next_rand();
    host_mcu_model_i.send(sel, v, x[9:0], x[10] ? 3 : 1);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    $display("BAD watchdog expected finish seen hang");
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    soft_reset = 1'b0;
    partial_mode = 1'b0;
    idle_enter = 1'b0;
    frame_start = 1'b0;
    disp_line = '0;
    rst_def = {TOP_FIXED_RESET, SCROLL_HEIGHT_RESET, BOTTOM_FIXED_RESET};
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    nrst = 1'b1;
    cycles(1);
    check_state(6'h00, 1'b0, 16'h0000, rst_def);
    wr(1'b0, CMD_REDUCED_COLOUR_EXIT);
    cycles(2);
    check_state(6'h00, 1'b0, 16'h0000, rst_def);
    idle_enter = 1'b1;
    cycles(1);
    idle_enter = 1'b0;
    top = 16'h000A;
    hgt = 16'h012C;
    wr(1'b0, CMD_SCROLL_AREA_DEFINE);
    wr(1'b1, top[15:8]);
    wr(1'b1, top[7:0]);
    wr(1'b1, hgt[15:8]);
    wr(1'b1, hgt[7:0]);
    wr(1'b1, top[15:8]);
    wr(1'b1, top[7:0]);
    r = next_rand();
    ptr = top + 16'(r % 32'(hgt));
    wr(1'b0, CMD_SCROLL_START);
    wr(1'b1, ptr[15:8]);
    wr(1'b1, ptr[7:0]);
    cycles(3);
    check_val("pointer_before_frame", 48'h0, 48'(scroll_pointer_value));
    frame_start = 1'b1;
    cycles(1);
    frame_start = 1'b0;
    cycles(1);
    check_state(6'h00, 1'b1, ptr, {top, hgt, top});
    // Corner bytes first, then random settings with both flip values
    for (int k = 0; k < 10; k++) begin
      r = next_rand();
      b = (k == 0) ? 8'hFC : (k == 1) ? 8'h03 : r[7:0];
      wr(1'b0, CMD_SCAN_DIRECTION);
      wr(1'b1, b);
      r = next_rand();
      disp_line = 16'(r % 32'd320);
      cycles(3);
      check_state(b[7:2], 1'b1, ptr, {top, hgt, top});
      check_val("fm_line", 48'(map_line(disp_line, b[4], top, hgt, ptr)), 48'(fm_line));
    end
    wr(1'b0, CMD_REDUCED_COLOUR_EXIT);
    cycles(2);
    check_state(b[7:2], 1'b0, ptr, {top, hgt, top});
    partial_mode = 1'b1;
    wr(1'b0, CMD_SCROLL_START);
    wr(1'b1, 8'h00);
    wr(1'b1, 8'h05);
    frame_start = 1'b1;
    cycles(1);
    frame_start = 1'b0;
    cycles(2);
    check_val("pointer_in_partial", 48'(ptr), 48'(scroll_pointer_value));
    partial_mode = 1'b0;
    b = 8'hA8;
    wr(1'b0, CMD_SCAN_DIRECTION);
    wr(1'b1, b);
    idle_enter = 1'b1;
    cycles(1);
    idle_enter = 1'b0;
    soft_reset = 1'b1;
    cycles(1);
    soft_reset = 1'b0;
    cycles(1);
    check_state(b[7:2], 1'b0, 16'h0000, rst_def);
    nrst = 1'b0;
    cycles(1);
    check_state(6'h00, 1'b0, 16'h0000, rst_def);
    nrst = 1'b1;
    cycles(2);
    complete_run();
  end
endmodule
